// >>> core/uie_enable_cell.sv
`timescale 1ns/1ps
module uie_enable_cell
	import uie_pkg::*;
(
	input  wire logic i_clk,  // system clock
	input  wire logic i_rst,  // sync reset, active high
	input  wire logic i_set,  // write one to set register
	input  wire logic i_clr,  // write one to clear register
	output logic      o_en    // enable state
);

	uie_cell_st_t s_q;
	uie_cell_st_t s_d;

	// =========================================================
	// set and clear sit at different offsets, never together
	always_comb begin
		s_d = s_q;
		if (i_set) begin
			s_d.bit_q = 1'b1;
		end else if (i_clr) begin
			s_d.bit_q = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s_q.bit_q <= EN_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_en = s_q.bit_q;

endmodule

// >>> core/uie_flag_cell.sv
`timescale 1ns/1ps
module uie_flag_cell
	import uie_pkg::*;
(
	input  wire logic i_clk,    // system clock
	input  wire logic i_rst,    // sync reset, active high
	input  wire logic i_event,  // event pulse
	input  wire logic i_clr,    // write one to clear
	output logic      o_flag    // sticky flag
);

	uie_cell_st_t s_q;
	uie_cell_st_t s_d;

	// =========================================================
	// a new event beats a clear in the same cycle
	always_comb begin
		s_d = s_q;
		if (i_event) begin
			s_d.bit_q = 1'b1;
		end else if (i_clr) begin
			s_d.bit_q = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s_q.bit_q <= FLAG_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_flag = s_q.bit_q;

endmodule

// >>> core/uie_irq_enable.sv
`timescale 1ns/1ps
module uie_irq_enable
	import uie_pkg::*;
(
	input  wire logic              i_clk,              // system clock
	input  wire logic              i_rst,              // sync reset, active high
	input  wire logic [ADDR_W-1:0] i_avs_address,      // byte address
	input  wire logic              i_avs_read,         // read request
	input  wire logic              i_avs_write,        // write request
	input  wire logic [DATA_W-1:0] i_avs_writedata,    // write data
	input  wire logic [3:0]        i_avs_byteenable,   // byte lanes
	output logic [DATA_W-1:0]      o_avs_readdata,     // read data
	output logic                   o_avs_waitrequest,  // stall
	input  wire logic [EVT_W-1:0]  i_event,            // event pulses
	output logic [EVT_W-1:0]       o_enable,           // enable state
	output logic                   o_irq               // interrupt level
);

	// =========================================================
	// state
	uie_top_st_t s_q;
	uie_top_st_t s_d;

	logic [EVT_W-1:0]  en;
	logic [EVT_W-1:0]  flags;
	logic [EVT_W-1:0]  pend;
	logic [DATA_W-1:0] lane_mask;
	logic [DATA_W-1:0] wmask;
	logic [EVT_W-1:0]  wbits;
	logic              req;
	logic              wr_fire;
	logic              hit_set;
	logic              hit_clr;
	logic              hit_flags;
	logic [EVT_W-1:0]  set_v;
	logic [EVT_W-1:0]  clr_v;
	logic [EVT_W-1:0]  flag_clr_v;

	// =========================================================
	// bus decode
	assign req       = i_avs_read | i_avs_write;
	assign wr_fire   = (s_q.st == ST_ACK) & i_avs_write;
	assign hit_set   = (i_avs_address == OFS_EN_SET);
	assign hit_clr   = (i_avs_address == OFS_EN_CLR);
	assign hit_flags = (i_avs_address == OFS_FLAGS);

	always_comb begin
		for (int b = 0; b < 4; b++) begin
			lane_mask[8*b +: 8] = {8{i_avs_byteenable[b]}};
		end
	end

	assign wmask = i_avs_writedata & lane_mask;
	// upper bits have no storage, writes to them are dropped
	assign wbits = wmask[EVT_W-1:0];

	// zero bits produce no strobe, so their enables hold
	assign set_v      = (wr_fire & hit_set)   ? wbits : '0;
	assign clr_v      = (wr_fire & hit_clr)   ? wbits : '0;
	assign flag_clr_v = (wr_fire & hit_flags) ? wbits : '0;

	// =========================================================
	// per-event enable and sticky flag
	for (genvar g = 0; g < EVT_W; g++) begin : g_bit
		uie_enable_cell u_en (
			.i_clk (i_clk),
			.i_rst (i_rst),
			.i_set (set_v[g]),
			.i_clr (clr_v[g]),
			.o_en  (en[g])
		);
		uie_flag_cell u_flag (
			.i_clk   (i_clk),
			.i_rst   (i_rst),
			.i_event (i_event[g]),
			.i_clr   (flag_clr_v[g]),
			.o_flag  (flags[g])
		);
	end

	// =========================================================
	// named views of the enable vector
	logic             en_bus_reset;
	logic             en_started;
	logic [NUM_EP-1:0] en_in_ep;
	logic             en_ctrl_done;
	logic             en_iso_in;
	logic [NUM_EP-1:0] en_out_ep;
	logic             en_iso_out;
	logic             en_sof;
	logic             en_bus_cond;
	logic             en_ctrl_setup;
	logic             en_ep_data;

	assign en_bus_reset  = en[BIT_BUS_RESET];
	assign en_started    = en[BIT_STARTED];
	assign en_in_ep      = en[BIT_IN_EP0 +: NUM_EP];
	assign en_ctrl_done  = en[BIT_CTRL_DONE];
	assign en_iso_in     = en[BIT_ISO_IN];
	assign en_out_ep     = en[BIT_OUT_EP0 +: NUM_EP];
	assign en_iso_out    = en[BIT_ISO_OUT];
	assign en_sof        = en[BIT_SOF];
	assign en_bus_cond   = en[BIT_BUS_COND];
	assign en_ctrl_setup = en[BIT_CTRL_SETUP];
	assign en_ep_data    = en[BIT_EP_DATA];

	// events gated by their own enables, in bit order
	assign pend = {
		flags[BIT_EP_DATA]    & en_ep_data,
		flags[BIT_CTRL_SETUP] & en_ctrl_setup,
		flags[BIT_BUS_COND]   & en_bus_cond,
		flags[BIT_SOF]        & en_sof,
		flags[BIT_ISO_OUT]    & en_iso_out,
		flags[BIT_OUT_EP0 +: NUM_EP] & en_out_ep,
		flags[BIT_ISO_IN]     & en_iso_in,
		flags[BIT_CTRL_DONE]  & en_ctrl_done,
		flags[BIT_IN_EP0 +: NUM_EP] & en_in_ep,
		flags[BIT_STARTED]    & en_started,
		flags[BIT_BUS_RESET]  & en_bus_reset
	};

	// =========================================================
	// next state: handshake, read capture, interrupt
	always_comb begin
		s_d = s_q;
		unique case (s_q.st)
			ST_IDLE: begin
				if (req) begin
					s_d.st = ST_ACK;
					if (i_avs_read) begin
						unique case (i_avs_address)
							// both views read the shared enable state
							OFS_EN_SET,
							OFS_EN_CLR: s_d.rdata = {{(DATA_W-EVT_W){1'b0}}, en};
							OFS_FLAGS:  s_d.rdata = {{(DATA_W-EVT_W){1'b0}}, flags};
							OFS_PEND:   s_d.rdata = {{(DATA_W-EVT_W){1'b0}}, pend};
							default:    s_d.rdata = RDATA_RST;
						endcase
					end else begin
						s_d.rdata = RDATA_RST;
					end
				end
			end
			ST_ACK: begin
				s_d.st = ST_IDLE;
			end
		endcase
		s_d.irq = |pend;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s_q.st    <= ST_IDLE;
			s_q.rdata <= RDATA_RST;
			s_q.irq   <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// =========================================================
	// outputs
	assign o_avs_readdata    = s_q.rdata;
	assign o_avs_waitrequest = (s_q.st != ST_ACK);
	assign o_enable          = en;
	assign o_irq             = s_q.irq;

	// =========================================================
	// assertions
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	a_bus_reset_en: assert property (
		wr_fire && hit_set && wbits[BIT_BUS_RESET] |=> en[BIT_BUS_RESET]
	) else $error("bus reset enable not set");

	a_started_en: assert property (
		wr_fire && hit_set && wbits[BIT_STARTED] |=> en[BIT_STARTED]
	) else $error("started enable not set");

	a_in_ep_en: assert property (
		wr_fire && hit_set |=>
			((en[BIT_IN_EP0 +: NUM_EP] & $past(wbits[BIT_IN_EP0 +: NUM_EP]))
			== $past(wbits[BIT_IN_EP0 +: NUM_EP]))
	) else $error("in endpoint enable not set");

	a_ctrl_done_en: assert property (
		wr_fire && hit_set && wbits[BIT_CTRL_DONE] |=> en[BIT_CTRL_DONE]
	) else $error("control done enable not set");

	a_iso_in_en: assert property (
		wr_fire && hit_set && wbits[BIT_ISO_IN] |=> en[BIT_ISO_IN]
	) else $error("iso in enable not set");

	a_out_ep_en: assert property (
		wr_fire && hit_set |=>
			((en[BIT_OUT_EP0 +: NUM_EP] & $past(wbits[BIT_OUT_EP0 +: NUM_EP]))
			== $past(wbits[BIT_OUT_EP0 +: NUM_EP]))
	) else $error("out endpoint enable not set");

	a_iso_out_en: assert property (
		wr_fire && hit_set && wbits[BIT_ISO_OUT] |=> en[BIT_ISO_OUT]
	) else $error("iso out enable not set");

	a_sof_en: assert property (
		wr_fire && hit_set && wbits[BIT_SOF] |=> en[BIT_SOF]
	) else $error("frame start enable not set");

	a_bus_cond_en: assert property (
		wr_fire && hit_set && wbits[BIT_BUS_COND] |=> en[BIT_BUS_COND]
	) else $error("bus condition enable not set");

	a_ctrl_setup_en: assert property (
		wr_fire && hit_set && wbits[BIT_CTRL_SETUP] |=> en[BIT_CTRL_SETUP]
	) else $error("setup enable not set");

	a_ep_data_en: assert property (
		wr_fire && hit_set && wbits[BIT_EP_DATA] |=> en[BIT_EP_DATA]
	) else $error("endpoint data enable not set");

	a_upper_zero: assert property (
		!o_avs_waitrequest |-> o_avs_readdata[DATA_W-1:EVT_W] == '0
	) else $error("unused read bits not zero");

	a_clear_disables: assert property (
		wr_fire && hit_clr |=> ((en & $past(wbits)) == '0)
	) else $error("clear write left enable on");

	a_clr_reads_en: assert property (
		i_avs_read && hit_clr && s_q.st == ST_IDLE |=>
			o_avs_readdata[EVT_W-1:0] == $past(en)
	) else $error("clear view reads wrong state");

	a_zero_keeps: assert property (
		wr_fire && hit_set |=> ((en & ~$past(wbits)) == ($past(en) & ~$past(wbits)))
	) else $error("zero bit changed an enable");

	a_idle_keeps: assert property (
		!wr_fire |=> en == $past(en)
	) else $error("enable changed without write");

	a_irq_follows: assert property (
		o_irq == $past(|(flags & en))
	) else $error("interrupt does not follow pending");

	a_one_wait: assert property (
		req && s_q.st == ST_IDLE |=> !o_avs_waitrequest ##1 o_avs_waitrequest
	) else $error("answer not after one cycle");

	a_flag_set_wins: assert property (
		i_event[BIT_SOF] |=> flags[BIT_SOF]
	) else $error("event lost against clear");

	// =========================================================
	// reset and bus timing
	a_reset_clean: assert property (
		$past(i_rst) |-> (en == '0) && (flags == '0) && !o_irq && o_avs_waitrequest
	) else $error("state not cleared by reset");

	a_single_answer: assert property (
		!o_avs_waitrequest |=> o_avs_waitrequest
	) else $error("answer held for more than one cycle");

	a_no_stray_answer: assert property (
		!req && s_q.st == ST_IDLE |=> o_avs_waitrequest
	) else $error("answer without a request");

	a_ack_after_req: assert property (
		!o_avs_waitrequest |-> $past(req && s_q.st == ST_IDLE)
	) else $error("answer not preceded by a taken request");

	a_read_stands: assert property (
		!(req && s_q.st == ST_IDLE) |=> $stable(o_avs_readdata)
	) else $error("read data changed without a request");

	// =========================================================
	// readback views
	a_set_reads_en: assert property (
		i_avs_read && hit_set && s_q.st == ST_IDLE |=>
			o_avs_readdata[EVT_W-1:0] == $past(en)
	) else $error("set view reads wrong state");

	a_flags_read: assert property (
		i_avs_read && hit_flags && s_q.st == ST_IDLE |=>
			o_avs_readdata == {{(DATA_W-EVT_W){1'b0}}, $past(flags)}
	) else $error("flag view reads wrong state");

	a_pend_read: assert property (
		i_avs_read && (i_avs_address == OFS_PEND) && s_q.st == ST_IDLE |=>
			o_avs_readdata == {{(DATA_W-EVT_W){1'b0}}, $past(flags & en)}
	) else $error("pending view reads wrong state");

	a_unmapped_zero: assert property (
		i_avs_read && s_q.st == ST_IDLE && !hit_set && !hit_clr && !hit_flags
			&& (i_avs_address != OFS_PEND) |=> o_avs_readdata == '0
	) else $error("unmapped read not zero");

	a_write_reads_zero: assert property (
		i_avs_write && s_q.st == ST_IDLE |=> o_avs_readdata == '0
	) else $error("write answer carries data");

	// =========================================================
	// enables, lanes and flags
	a_set_keeps_on: assert property (
		wr_fire && hit_set |=> (en & $past(en)) == $past(en)
	) else $error("set write cleared an enable");

	a_clr_zero_keeps: assert property (
		wr_fire && hit_clr |=> ((en ^ $past(en)) & ~$past(wbits)) == '0
	) else $error("clear write touched another enable");

	a_lane_gates: assert property (
		wr_fire && hit_set |=> ((en ^ $past(en)) & ~$past(lane_mask[EVT_W-1:0])) == '0
	) else $error("disabled byte lane changed an enable");

	a_event_sets: assert property (
		|i_event |=> (flags & $past(i_event)) == $past(i_event)
	) else $error("event did not set its flag");

	a_flag_clears: assert property (
		wr_fire && hit_flags |=> (flags & $past(wbits) & ~$past(i_event)) == '0
	) else $error("flag not cleared by write");

	a_flag_holds: assert property (
		!(wr_fire && hit_flags) |=> (flags & $past(flags)) == $past(flags)
	) else $error("flag dropped without a clear");

	a_flag_needs_event: assert property (
		(flags & ~$past(flags) & ~$past(i_event)) == '0
	) else $error("flag set without an event");

	a_irq_walk: assert property (
		(|(i_event & en)) && !wr_fire |-> ##2 o_irq
	) else $error("enabled event raised no interrupt");

	a_irq_drop: assert property (
		!(|(flags & en)) |=> !o_irq
	) else $error("interrupt without a pending event");

	c_set_write: cover property (wr_fire && hit_set && wbits != '0);
	c_clr_write: cover property (wr_fire && hit_clr && wbits != '0);
	c_irq_rise:  cover property ($rose(o_irq));
	c_race:      cover property (i_event[0] && flag_clr_v[0]);
	c_flag_clr:  cover property (wr_fire && hit_flags && wbits != '0);

endmodule

// >>> core/uie_pkg.sv
// Functional notes
// - bit 0 write one enables bus reset
// - bit 1 write one enables started event
// - bits 2..9 enable IN endpoint 0..7 ends
// - bit 10 enables control data step done
// - bit 11 enables iso IN transfer end
// - bits 12..19 enable OUT endpoint 0..7 ends
// - bit 20 enables iso OUT transfer end
// - bit 21 enables start of frame
// - bit 22 enables bus condition event
// - bit 23 enables control setup received
// - bit 24 endpoint data; 25..31 read zero
// - clear register at 0x308 disables, same readback
package uie_pkg;

	// =========================================================
	// widths
	localparam int EVT_W  = 25;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 12;
	localparam int NUM_EP = 8;

	// =========================================================
	// register offsets (byte addresses)
	localparam logic [ADDR_W-1:0] OFS_FLAGS  = 12'h100;
	localparam logic [ADDR_W-1:0] OFS_PEND   = 12'h104;
	localparam logic [ADDR_W-1:0] OFS_EN_SET = 12'h304;
	localparam logic [ADDR_W-1:0] OFS_EN_CLR = 12'h308;

	// =========================================================
	// field positions
	localparam int BIT_BUS_RESET  = 0;
	localparam int BIT_STARTED    = 1;
	localparam int BIT_IN_EP0     = 2;
	localparam int BIT_CTRL_DONE  = 10;
	localparam int BIT_ISO_IN     = 11;
	localparam int BIT_OUT_EP0    = 12;
	localparam int BIT_ISO_OUT    = 20;
	localparam int BIT_SOF        = 21;
	localparam int BIT_BUS_COND   = 22;
	localparam int BIT_CTRL_SETUP = 23;
	localparam int BIT_EP_DATA    = 24;

	// =========================================================
	// reset values
	localparam logic              EN_RST    = 1'b0;
	localparam logic              FLAG_RST  = 1'b0;
	localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

	// =========================================================
	// types
	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_ACK  = 1'b1
	} uie_bus_st_t;

	typedef struct packed {
		uie_bus_st_t        st;
		logic [DATA_W-1:0]  rdata;
		logic               irq;
	} uie_top_st_t;

	typedef struct packed {
		logic bit_q;
	} uie_cell_st_t;

endpackage

// >>> testbench/uie_irq_enable_bench.sv
`timescale 1ns/1ps
module uie_irq_enable_bench;
	import uie_pkg::*;

	// =========================================================
	// stimulus and design
	logic              i_clk            = 1'b0;
	logic              i_rst            = 1'b1;
	logic [ADDR_W-1:0] i_avs_address    = '0;
	logic              i_avs_read       = 1'b0;
	logic              i_avs_write      = 1'b0;
	logic [DATA_W-1:0] i_avs_writedata  = '0;
	logic [3:0]        i_avs_byteenable = 4'hf;
	logic [EVT_W-1:0]  i_event          = '0;
	logic [DATA_W-1:0] o_avs_readdata;
	logic              o_avs_waitrequest;
	logic [EVT_W-1:0]  o_enable;
	logic              o_irq;
	int                fail_count       = 0;
	int                num_checks       = 0;

	always #12.5 i_clk = ~i_clk;

	uie_irq_enable uie_irq_enable_inst (
		.i_clk            (i_clk),
		.i_rst            (i_rst),
		.i_avs_address    (i_avs_address),
		.i_avs_read       (i_avs_read),
		.i_avs_write      (i_avs_write),
		.i_avs_writedata  (i_avs_writedata),
		.i_avs_byteenable (i_avs_byteenable),
		.o_avs_readdata   (o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest),
		.i_event          (i_event),
		.o_enable         (o_enable),
		.o_irq            (o_irq)
	);

	// =========================================================
	// helpers
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// one transfer; held up to the rising edge at which waitrequest is sampled low
	task automatic bus(input logic is_wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
			input logic [3:0] be, output logic [31:0] q);
		int n = 0;
		@(posedge i_clk);
		i_avs_address <= a;
		i_avs_write <= is_wr;
		i_avs_read <= !is_wr;
		i_avs_writedata <= d;
		i_avs_byteenable <= be;
		// design updates by non-blocking assignment, so this sees the value at the edge
		do begin
			@(posedge i_clk);
			n++;
		end while (o_avs_waitrequest !== 1'b0 && n < 50);
		if (o_avs_waitrequest !== 1'b0) begin
			fail_count++;
			$display("ERROR t=%0t bus timeout", $time);
			test_done();
		end
		q = o_avs_readdata;
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, 4'hf, q);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string what);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, 4'hf, q);
		chk(q, exp, what);
	endtask

	// event high for one edge, then wait until the registered irq has settled
	task automatic pulse(input int b);
		@(posedge i_clk);
		i_event <= 25'h1 << b;
		@(posedge i_clk);
		i_event <= '0;
		@(posedge i_clk);
		@(negedge i_clk);
	endtask

	task automatic settle();
		@(posedge i_clk);
		@(negedge i_clk);
	endtask

	// =========================================================
	// sequence
	initial begin
		logic [31:0] q;
		int          nb;
		repeat (12) @(posedge i_clk);
		i_rst <= 1'b0;
		@(negedge i_clk);
		chk(32'(o_enable), 32'h0, "enable after reset");
		chk(32'(o_irq), 32'h0, "irq after reset");
		rd(OFS_EN_SET, 32'h0, "set reg reset");
		rd(OFS_EN_CLR, 32'h0, "clr reg reset");
		$display("done: reset values");

		for (int b = 0; b < EVT_W; b++) begin
			nb = (b + 1) % EVT_W;
			wr(OFS_EN_CLR, 32'hffff_ffff);
			wr(OFS_EN_SET, 32'h1 << b);
			rd(OFS_EN_SET, 32'h1 << b, "set readback");
			rd(OFS_EN_CLR, 32'h1 << b, "clr readback");
			chk(32'(o_enable), 32'h1 << b, "enable bit");
			pulse(nb);
			chk(32'(o_irq), 32'h0, "irq other event");
			pulse(b);
			chk(32'(o_irq), 32'h1, "irq own event");
			rd(OFS_PEND, 32'h1 << b, "pending");
			wr(OFS_EN_CLR, 32'h1 << b);
			settle();
			chk(32'(o_irq), 32'h0, "irq masked");
			rd(OFS_FLAGS, (32'h1 << b) | (32'h1 << nb), "flags");
			wr(OFS_FLAGS, (32'h1 << b) | (32'h1 << nb));
			rd(OFS_FLAGS, 32'h0, "flags cleared");
		end
		$display("done: per bit enable and interrupt");

		wr(OFS_EN_SET, 32'hffff_ffff);
		rd(OFS_EN_SET, 32'h01ff_ffff, "upper bits zero");
		wr(OFS_EN_SET, 32'h0);
		rd(OFS_EN_SET, 32'h01ff_ffff, "zero write keeps");
		wr(OFS_EN_CLR, 32'h0000_ff00);
		rd(OFS_EN_CLR, 32'h01ff_00ff, "partial clear");
		wr(12'h200, 32'hffff_ffff);
		rd(12'h200, 32'h0, "unmapped read");
		rd(OFS_EN_SET, 32'h01ff_00ff, "unmapped write ignored");
		$display("done: set, clear and unmapped");

		wr(OFS_EN_CLR, 32'hffff_ffff);
		bus(1'b1, OFS_EN_SET, 32'hffff_ffff, 4'h2, q);
		rd(OFS_EN_SET, 32'h0000_ff00, "byte lane one only");
		pulse(9);
		chk(32'(o_irq), 32'h1, "irq in ep7");
		// event lands on the very edge at which the flag clear takes effect
		fork
			wr(OFS_FLAGS, 32'h1 << BIT_SOF);
			begin
				repeat (2) @(posedge i_clk);
				i_event <= 25'h1 << BIT_SOF;
				@(posedge i_clk);
				i_event <= '0;
			end
		join
		rd(OFS_FLAGS, (32'h1 << 9) | (32'h1 << BIT_SOF), "event beats clear");
		@(posedge i_clk);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		@(negedge i_clk);
		chk(32'(o_enable), 32'h0, "enable after second reset");
		chk(32'(o_irq), 32'h0, "irq after second reset");
		rd(OFS_FLAGS, 32'h0, "flags after second reset");
		$display("done: byte lanes and second reset");
		test_done();
	end
endmodule
